// >>> src/cts_pkg.sv
// Behaviour
// - status bit 12 shows drive follows command
// - follow flag cleared outside operation enabled
// - follow flag cleared during any deceleration
// - follow flag cleared while halt is held
// - overtravel in command direction clears follow flag
// - setup bit 11 zero lets limiting clear
// - read-only status word, reserved bits zero
// - effective torque is target plus offset
// - setpoint update period equals communication cycle
// - selection five uses separate positive/negative limits
// - other selections use first torque limit
// - velocity limited to maximum motor speed
// - monitor values returned to the master
// - setup bit 11 set removes limiting as condition
package cts_pkg;

  ////////////////////////////////////////////////////////////////
  // object indices
  localparam logic [15:0] IDX_SETUP3 = 16'h3724;
  localparam logic [15:0] IDX_ERR = 16'h603F;
  localparam logic [15:0] IDX_STATUS = 16'h6041;
  localparam logic [15:0] IDX_POS_INT = 16'h6063;
  localparam logic [15:0] IDX_POS_ACT = 16'h6064;
  localparam logic [15:0] IDX_VEL_SENS = 16'h6069;
  localparam logic [15:0] IDX_VEL_ACT = 16'h606C;
  localparam logic [15:0] IDX_TQ_DEM = 16'h6074;
  localparam logic [15:0] IDX_RATED_CUR = 16'h6075;
  localparam logic [15:0] IDX_RATED_TQ = 16'h6076;
  localparam logic [15:0] IDX_TQ_ACT = 16'h6077;
  localparam logic [15:0] IDX_CUR_ACT = 16'h6078;
  localparam logic [15:0] IDX_LINK_V = 16'h6079;
  localparam logic [15:0] IDX_PROBE_ST = 16'h60B9;
  localparam logic [15:0] IDX_P1_RISE = 16'h60BA;
  localparam logic [15:0] IDX_P1_FALL = 16'h60BB;
  localparam logic [15:0] IDX_P2_RISE = 16'h60BC;
  localparam logic [15:0] IDX_P2_FALL = 16'h60BD;
  localparam logic [15:0] IDX_DIN = 16'h60FD;

  ////////////////////////////////////////////////////////////////
  // status word fields and setup values
  localparam int SW_RTSO = 0;
  localparam int SW_SO = 1;
  localparam int SW_OE = 2;
  localparam int SW_FAULT = 3;
  localparam int SW_VE = 4;
  localparam int SW_QS = 5;
  localparam int SW_SOD = 6;
  localparam int SW_WARN = 7;
  localparam int SW_REMOTE = 9;
  localparam int SW_ILA = 11;
  localparam int SW_FOLLOW = 12;
  localparam int SETUP3_LIM_EXCL = 11;
  localparam logic [15:0] SETUP3_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [7:0] TQ_SEL_PAIR = 8'h05;
  localparam logic signed [15:0] TQ_ZERO = 16'sh0000;

  ////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic ready_to_switch_on;
    logic switched_on;
    logic operation_enabled;
    logic fault;
    logic voltage_enabled_flag;
    logic quick_stop_flag;
    logic switch_on_disabled;
    logic warning;
    logic remote_control_indicator;
  } cts_pds_t;

  typedef struct packed {
    logic halt;
    logic overtravel;
    logic quick_stop;
    logic shutdown;
    logic disable_op;
    logic fault;
  } cts_decel_t;

  typedef struct packed {
    logic signed [15:0] target;
    logic signed [15:0] offset;
    logic [7:0] lim_sel;
    logic [15:0] pos_lim;
    logic [15:0] neg_lim;
    logic [15:0] first_lim;
    logic [31:0] max_speed;
  } cts_set_t;

  typedef struct packed {
    logic [31:0] pos_int;
    logic [31:0] pos_act;
    logic [31:0] vel_sens;
    logic [31:0] vel_act;
    logic [15:0] tq_demand;
    logic [31:0] rated_cur;
    logic [31:0] rated_tq;
    logic [15:0] tq_act;
    logic [15:0] cur_act;
    logic [31:0] link_v;
    logic [15:0] err_code;
    logic [15:0] probe_st;
    logic [31:0] p1_rise;
    logic [31:0] p1_fall;
    logic [31:0] p2_rise;
    logic [31:0] p2_fall;
    logic [31:0] din;
  } cts_mon_t;

endpackage : cts_pkg

// >>> src/cts_pin_sync.sv
`timescale 1ns/1ps
// pin synchroniser with agreement filter
module cts_pin_sync
  import cts_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // pin in, filtered level out
  input wire logic pin,
  output logic level
);

  logic s1_ff; // metastability stage, read by s2 only
  logic s2_ff; // second stage
  logic s3_ff; // third stage
  logic level_ff; // accepted level

  ////////////////////////////////////////////////////////////////
  // three-stage chain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // change accepted once stages two and three agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign level = level_ff;

endmodule : cts_pin_sync

// >>> src/cts_clamp.sv
`timescale 1ns/1ps
// registered symmetric/asymmetric torque clamp
module cts_clamp
  import cts_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // summed command and limit magnitudes
  input wire logic signed [16:0] sum,
  input wire logic [15:0] pos_lim,
  input wire logic [15:0] neg_lim,
  // clamped command and hit flag
  output logic signed [15:0] q,
  output logic hit
);

  localparam logic signed [17:0] MAG_MAX = 18'sh07FFF; // largest 16-bit magnitude

  logic signed [17:0] sum_e; // widened sum
  logic signed [17:0] pos_e; // positive bound
  logic signed [17:0] neg_e; // negative bound
  logic signed [15:0] q_ff; // clamped result
  logic hit_ff; // limit engaged

  // widen and cap limits to the representable range
  always_comb begin
    sum_e = 18'(sum);
    pos_e = $signed({2'b00, pos_lim});
    neg_e = $signed({2'b00, neg_lim});
    if (pos_e > MAG_MAX) begin
      pos_e = MAG_MAX;
    end
    if (neg_e > MAG_MAX) begin
      neg_e = MAG_MAX;
    end
    neg_e = -neg_e;
  end

  ////////////////////////////////////////////////////////////////
  // clamp register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= TQ_ZERO;
      hit_ff <= 1'b0;
    end else if (sum_e > pos_e) begin
      q_ff <= pos_e[15:0];
      hit_ff <= 1'b1;
    end else if (sum_e < neg_e) begin
      q_ff <= neg_e[15:0];
      hit_ff <= 1'b1;
    end else begin
      q_ff <= sum_e[15:0];
      hit_ff <= 1'b0;
    end
  end

  assign q = q_ff;
  assign hit = hit_ff;

endmodule : cts_clamp

// >>> src/cts_torque_ctrl.sv
`timescale 1ns/1ps
// cyclic torque command path, follow flag and monitor objects
module cts_torque_ctrl
  import cts_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // cycle strobe from the link logic
  input wire logic cycle_sync,
  // cyclic setpoints and limits
  input wire cts_set_t set_in,
  // drive state and deceleration causes
  input wire cts_pds_t pds_in,
  input wire cts_decel_t decel_in,
  input wire logic halt_active,
  // overtravel pins
  input wire logic positive_overtravel_input,
  input wire logic negative_overtravel_input,
  // live monitor values
  input wire cts_mon_t mon_in,
  // object access port
  input wire logic obj_rd,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  // command and status out
  output logic signed [15:0] torque_cmd,
  output logic [15:0] status_word,
  output logic cycle_done
);

  ////////////////////////////////////////////////////////////////
  // declarations
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SUM = 4'b0010,
    ST_CLAMP = 4'b0100,
    ST_PUB = 4'b1000
  } cts_state_t;

  cts_state_t state_ff; // cycle sequencer state
  cts_state_t nxt_state; // next sequencer state
  logic [15:0] setup3_ff; // extended setup word
  logic signed [16:0] sum_ff; // target plus offset
  logic [15:0] pos_lim_ff; // chosen positive bound
  logic [15:0] neg_lim_ff; // chosen negative bound
  logic [31:0] max_speed_ff; // velocity bound
  logic signed [15:0] clamp_q; // clamp output
  logic clamp_hit; // torque limit engaged
  logic signed [15:0] cmd_ff; // command to current loop
  logic vel_hit_ff; // velocity limit engaged
  logic tq_hit_ff; // torque limit held for status
  logic [15:0] status_ff; // published status word
  cts_mon_t mon_ff; // cycle snapshot of monitors
  logic [31:0] rdata_ff; // read data
  logic ack_ff; // access answer
  logic err_ff; // access refused
  logic done_ff; // cycle finished pulse
  logic pot_lvl; // filtered positive overtravel
  logic not_lvl; // filtered negative overtravel
  logic signed [32:0] vel_e; // widened actual velocity
  logic signed [32:0] spd_e; // widened speed bound
  logic vel_over_pos; // above positive speed
  logic vel_over_neg; // below negative speed
  logic vel_block; // command pushes further past speed
  logic ovt_block; // overtravel in command direction
  logic lim_count; // limiting counts against follow
  logic follow_now; // all follow conditions met
  logic kill_now; // immediate clear condition

  ////////////////////////////////////////////////////////////////
  // overtravel pin synchronisers
  cts_pin_sync u_pot_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin(positive_overtravel_input),
    .level(pot_lvl)
  );

  cts_pin_sync u_not_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin(negative_overtravel_input),
    .level(not_lvl)
  );

  ////////////////////////////////////////////////////////////////
  // cycle sequencer: one pass per communication cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // wait for the interpolation period strobe
      ST_IDLE: begin
        if (cycle_sync) begin
          nxt_state = ST_SUM;
        end
      end
      // sum latched, clamp works
      ST_SUM: begin
        nxt_state = ST_CLAMP;
      end
      // clamp result ready, apply speed bound
      ST_CLAMP: begin
        nxt_state = ST_PUB;
      end
      // publish status and monitors
      ST_PUB: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////
  // setpoint capture: master supplies each cycle, no profile here
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_ff <= 17'sh00000;
      pos_lim_ff <= 16'h0000;
      neg_lim_ff <= 16'h0000;
      max_speed_ff <= 32'h00000000;
    end else if (state_ff == ST_IDLE && cycle_sync) begin
      // setpoints taken as sent, drive generates no trajectory
      sum_ff <= 17'(set_in.target) + 17'(set_in.offset);
      max_speed_ff <= set_in.max_speed;
      if (set_in.lim_sel == TQ_SEL_PAIR) begin
        pos_lim_ff <= set_in.pos_lim;
        neg_lim_ff <= set_in.neg_lim;
      end else begin
        pos_lim_ff <= set_in.first_lim;
        neg_lim_ff <= set_in.first_lim;
      end
    end
  end

  cts_clamp u_clamp (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sum(sum_ff),
    .pos_lim(pos_lim_ff),
    .neg_lim(neg_lim_ff),
    .q(clamp_q),
    .hit(clamp_hit)
  );

  ////////////////////////////////////////////////////////////////
  // speed bound: stop adding torque that drives past max speed
  always_comb begin
    vel_e = 33'(signed'(mon_in.vel_act));
    spd_e = $signed({1'b0, max_speed_ff});
    vel_over_pos = vel_e > spd_e;
    vel_over_neg = vel_e < -spd_e;
    vel_block = (vel_over_pos && clamp_q > TQ_ZERO) ||
                (vel_over_neg && clamp_q < TQ_ZERO);
  end

  // command register, updated once per cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff <= TQ_ZERO;
      vel_hit_ff <= 1'b0;
      tq_hit_ff <= 1'b0;
    end else if (state_ff == ST_CLAMP) begin
      cmd_ff <= vel_block ? TQ_ZERO : clamp_q;
      vel_hit_ff <= vel_block;
      tq_hit_ff <= clamp_hit;
    end
  end

  ////////////////////////////////////////////////////////////////
  // follow conditions
  always_comb begin
    ovt_block = (pot_lvl && cmd_ff > TQ_ZERO) ||
                (not_lvl && cmd_ff < TQ_ZERO);
    lim_count = !setup3_ff[SETUP3_LIM_EXCL] &&
                (tq_hit_ff || vel_hit_ff);
    kill_now = !pds_in.operation_enabled ||
               (|decel_in) ||
               halt_active ||
               ovt_block;
    follow_now = !kill_now && !lim_count;
  end

  ////////////////////////////////////////////////////////////////
  // status word, reserved bits zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= STATUS_RST;
    end else if (state_ff == ST_PUB) begin
      status_ff <= STATUS_RST;
      status_ff[SW_RTSO] <= pds_in.ready_to_switch_on;
      status_ff[SW_SO] <= pds_in.switched_on;
      status_ff[SW_OE] <= pds_in.operation_enabled;
      status_ff[SW_FAULT] <= pds_in.fault;
      status_ff[SW_VE] <= pds_in.voltage_enabled_flag;
      status_ff[SW_QS] <= pds_in.quick_stop_flag;
      status_ff[SW_SOD] <= pds_in.switch_on_disabled;
      status_ff[SW_WARN] <= pds_in.warning;
      status_ff[SW_REMOTE] <= pds_in.remote_control_indicator;
      status_ff[SW_ILA] <= tq_hit_ff || vel_hit_ff;
      status_ff[SW_FOLLOW] <= follow_now;
    end else if (kill_now) begin
      // follow bit dropped at once on a clear cause
      status_ff[SW_FOLLOW] <= 1'b0;
    end
  end

  // monitor snapshot, consistent within one cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_ff <= '0;
    end else if (state_ff == ST_PUB) begin
      mon_ff <= mon_in;
    end
  end

  // cycle finished pulse
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == ST_PUB);
    end
  end

  ////////////////////////////////////////////////////////////////
  // setup word: only writable object
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup3_ff <= SETUP3_RST;
    end else if (obj_wr && obj_index == IDX_SETUP3) begin
      setup3_ff <= obj_wdata[15:0];
    end
  end

  // object read and answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= obj_rd || obj_wr;
      err_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      if (obj_wr) begin
        // every object but the setup word is read-only
        err_ff <= (obj_index != IDX_SETUP3);
      end else if (obj_rd) begin
        case (obj_index)
          IDX_SETUP3: rdata_ff <= {16'h0000, setup3_ff};
          IDX_ERR: rdata_ff <= {16'h0000, mon_ff.err_code};
          IDX_STATUS: rdata_ff <= {16'h0000, status_ff};
          IDX_POS_INT: rdata_ff <= mon_ff.pos_int;
          IDX_POS_ACT: rdata_ff <= mon_ff.pos_act;
          IDX_VEL_SENS: rdata_ff <= mon_ff.vel_sens;
          IDX_VEL_ACT: rdata_ff <= mon_ff.vel_act;
          IDX_TQ_DEM: rdata_ff <= {16'h0000, mon_ff.tq_demand};
          IDX_RATED_CUR: rdata_ff <= mon_ff.rated_cur;
          IDX_RATED_TQ: rdata_ff <= mon_ff.rated_tq;
          IDX_TQ_ACT: rdata_ff <= {16'h0000, mon_ff.tq_act};
          IDX_CUR_ACT: rdata_ff <= {16'h0000, mon_ff.cur_act};
          IDX_LINK_V: rdata_ff <= mon_ff.link_v;
          IDX_PROBE_ST: rdata_ff <= {16'h0000, mon_ff.probe_st};
          IDX_P1_RISE: rdata_ff <= mon_ff.p1_rise;
          IDX_P1_FALL: rdata_ff <= mon_ff.p1_fall;
          IDX_P2_RISE: rdata_ff <= mon_ff.p2_rise;
          IDX_P2_FALL: rdata_ff <= mon_ff.p2_fall;
          IDX_DIN: rdata_ff <= mon_ff.din;
          // unknown index: zero data, refused
          default: err_ff <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign obj_rdata = rdata_ff;
  assign obj_ack = ack_ff;
  assign obj_err = err_ff;
  assign torque_cmd = cmd_ff;
  assign status_word = status_ff;
  assign cycle_done = done_ff;

endmodule : cts_torque_ctrl

// >>> verif/cts_torque_ctrl_asserts.sv
`timescale 1ns/1ps
module cts_torque_ctrl_asserts
  import cts_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // watched inputs
  input wire logic cycle_sync,
  input wire cts_set_t set_in,
  input wire cts_pds_t pds_in,
  input wire cts_decel_t decel_in,
  input wire logic halt_active,
  input wire logic positive_overtravel_input,
  input wire logic obj_rd,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  // watched outputs
  input wire logic [31:0] obj_rdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic signed [15:0] torque_cmd,
  input wire logic [15:0] status_word,
  input wire logic cycle_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // follow flag tap
  wire logic fol = status_word[SW_FOLLOW];
  ////////////////////////////////////////////////////////////////
  AST_ACK_NEXT:
    assert property ((obj_rd || obj_wr) |=> obj_ack) else $error("no ack after request");
  AST_IDLE_QUIET:
    assert property (!(obj_rd || obj_wr) |=> !obj_ack && obj_rdata == 32'h0)
    else $error("ack or data without request");
  AST_WR_RO:
    assert property (obj_wr && obj_index != IDX_SETUP3 |=> obj_err) else $error("ro write taken");
  AST_RESERVED:
    assert property (status_word[15:13] == 3'h0 && !status_word[10] && !status_word[8])
    else $error("reserved status bit set");
  AST_NOT_OE:
    assert property (!pds_in.operation_enabled [*3] |-> !fol) else $error("follow outside oe");
  AST_DECEL:
    assert property ((|decel_in) ##1 (|decel_in) ##1 (|decel_in) |-> !fol)
    else $error("follow during decel");
  AST_HALT:
    assert property (halt_active throughout (##2 1'b1) |-> !fol) else $error("follow in halt");
  AST_POT:
    assert property ((positive_overtravel_input && torque_cmd > 0) [*7] |-> !fol)
    else $error("follow into overtravel");
  AST_DONE_LAT:
    assert property (cycle_done |-> $past(cycle_sync, 4)) else $error("done not 4 after sync");
  AST_CLAMP_FIRST:
    assert property (cycle_sync && set_in.lim_sel != TQ_SEL_PAIR |-> ##3
      (int'(torque_cmd) <= int'({1'b0, $past(set_in.first_lim, 3)})) &&
      (int'(torque_cmd) >= -int'({1'b0, $past(set_in.first_lim, 3)})))
    else $error("first limit exceeded");
  // main scenarios
  COV_FOLLOW: cover property (cycle_done && fol);
  COV_LIMIT: cover property (cycle_done && status_word[SW_ILA]);
  COV_ERR: cover property (obj_ack && obj_err);
endmodule : cts_torque_ctrl_asserts

bind cts_torque_ctrl cts_torque_ctrl_asserts chk_u (.ref_clk, .arst_n, .cycle_sync, .set_in,
  .pds_in, .decel_in, .halt_active, .positive_overtravel_input, .obj_rd, .obj_wr, .obj_index,
  .obj_rdata, .obj_ack, .obj_err, .torque_cmd, .status_word, .cycle_done);

// >>> verif/cts_master_model.sv
`timescale 1ns/1ps
// network master: cycle strobe and fresh setpoints
module cts_master_model
  import cts_pkg::*;
#(
  parameter int PERIOD = 16, // cycles per comm cycle
  parameter int HOLD = 8 // shortened wait after enable
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bench plan
  input wire logic op_enabled,
  input wire cts_set_t plan,
  // to drive
  output logic cycle_sync,
  output cts_set_t set_in
);
  int cnt_ff; // period counter
  int hold_ff; // cycles since enable
  ////////////////////////////////////////////////////////////////
  // one strobe per period, period equals comm cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 0;
      cycle_sync <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
      cycle_sync <= (cnt_ff == PERIOD - 1);
    end
  end
  // wait after enable before real commands
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) hold_ff <= 0;
    else if (!op_enabled) hold_ff <= 0;
    else if (hold_ff < HOLD) hold_ff <= hold_ff + 1;
  end
  // trajectory is ours: new setpoints with each strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) set_in <= '0;
    else if (cnt_ff == PERIOD - 1) begin
      set_in <= plan;
      if (hold_ff < HOLD) begin
        set_in.target <= TQ_ZERO;
        set_in.offset <= TQ_ZERO;
      end
    end
  end
endmodule : cts_master_model

// >>> verif/test_cts_torque_ctrl.sv
`timescale 1ns/1ps
module test_cts_torque_ctrl;
  import cts_pkg::*;
  logic ref_clk, arst_n, cycle_sync, halt_active, obj_rd, obj_wr, obj_ack, obj_err, cycle_done;
  logic positive_overtravel_input, negative_overtravel_input;
  cts_set_t set_in, plan;
  cts_pds_t pds_in;
  cts_decel_t decel_in;
  cts_mon_t mon_in;
  logic [15:0] obj_index, status_word;
  logic [31:0] obj_wdata, obj_rdata;
  logic signed [15:0] torque_cmd;
  int err_count, checks_done;
  ////////////////////////////////////////////////////////////////
  cts_master_model mstr_u (.ref_clk, .arst_n, .op_enabled(pds_in.operation_enabled), .plan,
    .cycle_sync, .set_in);
  cts_torque_ctrl dut_u (.ref_clk, .arst_n, .cycle_sync, .set_in, .pds_in, .decel_in,
    .halt_active, .positive_overtravel_input, .negative_overtravel_input, .mon_in, .obj_rd,
    .obj_wr, .obj_index, .obj_wdata, .obj_rdata, .obj_ack, .obj_err, .torque_cmd,
    .status_word, .cycle_done);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one object read or write
  task automatic obj(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     input logic [31:0] exp, input logic ex_err);
    @(posedge ref_clk);
    #1;
    obj_wr = wr;
    obj_rd = !wr;
    obj_index = idx;
    obj_wdata = wd;
    @(posedge ref_clk);
    #1;
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    check({obj_ack, obj_err}, {1'b1, ex_err});
    if (!wr) check(obj_rdata, exp);
  endtask : obj
  // two published passes, bounded wait
  task automatic two_done();
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (cycle_done !== 1'b1 && n < 64);
      if (n >= 64) check(32'h0, 32'h1);
    end
    #1;
  endtask : two_done
  // new setpoint plan, speed bound 1000
  task automatic pass(input logic signed [15:0] tg, input logic signed [15:0] ofs,
                      input logic [7:0] sel, input logic [15:0] lp, input logic [15:0] ln,
                      input logic [15:0] lf);
    plan = '{tg, ofs, sel, lp, ln, lf, 32'h0000_03E8};
    two_done();
  endtask : pass
  // expected status word
  function automatic logic [15:0] sw(input logic fol, input logic ila);
    sw = {3'h0, fol, ila, 1'b0, pds_in.remote_control_indicator, 1'b0, pds_in.warning,
          pds_in.switch_on_disabled, pds_in.quick_stop_flag, pds_in.voltage_enabled_flag,
          pds_in.fault, pds_in.operation_enabled, pds_in.switched_on, pds_in.ready_to_switch_on};
  endfunction : sw
  ////////////////////////////////////////////////////////////////
  // object map access kinds
  task automatic s_regs();
    obj(1'b0, IDX_STATUS, 32'h0, {16'h0, STATUS_RST}, 1'b0);
    obj(1'b1, IDX_STATUS, 32'h0000_FFFF, 32'h0, 1'b1);
    obj(1'b0, IDX_SETUP3, 32'h0, {16'h0, SETUP3_RST}, 1'b0);
    obj(1'b1, IDX_SETUP3, 32'h0000_0800, 32'h0, 1'b0);
    obj(1'b0, IDX_SETUP3, 32'h0, 32'h0000_0800, 1'b0);
    obj(1'b1, IDX_SETUP3, 32'h0, 32'h0, 1'b0);
    obj(1'b0, 16'h6000, 32'h0, 32'h0, 1'b1);
    obj(1'b1, IDX_TQ_ACT, 32'h1, 32'h0, 1'b1);
  endtask : s_regs
  // sum, status flags, snapshot monitors
  task automatic s_follow();
    pds_in = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    mon_in.tq_act = 16'h1234;
    mon_in.rated_tq = 32'h89AB_CDEF;
    mon_in.pos_act = 32'h1357_9BDF;
    mon_in.cur_act = 16'hFEDC;
    mon_in.link_v = 32'h0002_4680;
    pass(16'sh012C, 16'sh00C8, 8'h00, 16'h0, 16'h0, 16'h03E8);
    check(torque_cmd, 32'h0000_01F4);
    check(status_word, sw(1'b1, 1'b0));
    mon_in.tq_act = 16'h5678;
    obj(1'b0, IDX_TQ_ACT, 32'h0, 32'h0000_1234, 1'b0);
    obj(1'b0, IDX_RATED_TQ, 32'h0, 32'h89AB_CDEF, 1'b0);
    obj(1'b0, IDX_POS_ACT, 32'h0, 32'h1357_9BDF, 1'b0);
    obj(1'b0, IDX_CUR_ACT, 32'h0, 32'h0000_FEDC, 1'b0);
    obj(1'b0, IDX_LINK_V, 32'h0, 32'h0002_4680, 1'b0);
  endtask : s_follow
  // clamps, speed bound, limit exclusion bit
  task automatic s_limits();
    pass(16'sh012C, 16'sh00C8, 8'h03, 16'h0, 16'h0, 16'h0190);
    check(torque_cmd, 32'h0000_0190);
    check(status_word, sw(1'b0, 1'b1));
    obj(1'b1, IDX_SETUP3, 32'h0000_0800, 32'h0, 1'b0);
    two_done();
    check(status_word, sw(1'b1, 1'b1));
    obj(1'b1, IDX_SETUP3, 32'h0, 32'h0, 1'b0);
    pass(-16'sh012C, -16'sh0064, TQ_SEL_PAIR, 16'h03E8, 16'h00FA, 16'h0064);
    check(torque_cmd, -32'sh0000_00FA);
    pass(16'sh0064, 16'sh00C8, TQ_SEL_PAIR, 16'h00FA, 16'h03E8, 16'h0064);
    check(torque_cmd, 32'h0000_00FA);
    mon_in.vel_act = 32'h0000_1388;
    pass(16'sh012C, 16'sh0000, 8'h00, 16'h0, 16'h0, 16'h03E8);
    check(torque_cmd, 32'h0);
    check(status_word[SW_FOLLOW], 1'b0);
    mon_in.vel_act = 32'hFFFF_EC78;
    pass(-16'sh012C, 16'sh0000, 8'h00, 16'h0, 16'h0, 16'h03E8);
    check(torque_cmd, 32'h0);
    mon_in.vel_act = 32'h0;
  endtask : s_limits
  // each clear cause drops the follow flag
  task automatic s_causes();
    pass(16'sh012C, 16'sh0000, 8'h00, 16'h0, 16'h0, 16'h03E8);
    check(status_word[SW_FOLLOW], 1'b1);
    for (int i = 0; i < 6; i++) begin
      decel_in = cts_decel_t'(6'h01 << i);
      two_done();
      check(status_word[SW_FOLLOW], 1'b0);
      decel_in = '0;
    end
    halt_active = 1'b1;
    two_done();
    check(status_word[SW_FOLLOW], 1'b0);
    halt_active = 1'b0;
    pds_in.operation_enabled = 1'b0;
    two_done();
    check(status_word[SW_FOLLOW], 1'b0);
    pds_in.operation_enabled = 1'b1;
    negative_overtravel_input = 1'b1;
    two_done();
    check(status_word[SW_FOLLOW], 1'b1);
    pass(-16'sh012C, 16'sh0000, 8'h00, 16'h0, 16'h0, 16'h03E8);
    check(status_word[SW_FOLLOW], 1'b0);
    negative_overtravel_input = 1'b0;
    positive_overtravel_input = 1'b1;
    pass(16'sh012C, 16'sh0000, 8'h00, 16'h0, 16'h0, 16'h03E8);
    check(status_word[SW_FOLLOW], 1'b0);
    positive_overtravel_input = 1'b0;
  endtask : s_causes
  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    {halt_active, obj_rd, obj_wr, positive_overtravel_input, negative_overtravel_input} = '0;
    {plan, pds_in, decel_in, mon_in, obj_index, obj_wdata} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    s_regs();
    s_follow();
    s_limits();
    s_causes();
    close_out();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    close_out();
  end
endmodule : test_cts_torque_ctrl
